/* File: clk_fanout_pkg.sv */
/*
  Shared constants and carrier types for the clock fan-out block.
  Assumes a single 25 MHz system clock. The reference clock is sampled by it,
  so the reference must stay well below half that rate.
*/
package clk_fanout_pkg;

  // ****************************************
  // Clock and sizing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int PERIOD_W = 16;
  localparam int BANK_A_N = 5;
  localparam int BANK_B_N = 4;
  localparam int LOCK_W = 24;
  localparam logic [LOCK_W-1:0] LOCK_CYCLES_DEF = 24'h000400;
  localparam logic [PERIOD_W-1:0] PERIOD_TOL = 16'h0001;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hFFFF;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;
  localparam int SYNC_W = 5;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic ref_clk;
    logic loop_feedback_in;
    logic bank_a_enable;
    logic bank_b_enable;
    logic analog_supply_bypass_strap;
  } pin_in_t;

  typedef struct packed {
    logic [BANK_A_N-1:0] bank_a;
    logic [BANK_B_N-1:0] bank_b;
    logic fb_out;
  } clk_out_t;

endpackage

/* File: clk_fanout_properties.sv */
/* Port assertions for the clock fan-out block.
   Assumes a ref period of at least four cycles and a nonzero lock count. */
`timescale 1ns/1ps
module clk_fanout_properties #(
  parameter logic [clk_fanout_pkg::LOCK_W-1:0] LOCK_CYCLES = clk_fanout_pkg::LOCK_CYCLES_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ref_clk,
  input wire logic i_bank_a_enable,
  input wire logic i_bank_b_enable,
  input wire logic i_analog_supply_bypass_strap,
  input wire logic [clk_fanout_pkg::BANK_A_N-1:0] o_bank_a_clock_outs,
  input wire logic [clk_fanout_pkg::BANK_B_N-1:0] o_bank_b_clock_outs,
  input wire logic o_loop_feedback_out,
  input wire logic o_loop_locked
);
  // ****************
  // Enable-low age
  // ****************
  // Saturates at 15: covers sync plus the wait for the low phase
  logic [3:0] a_off_ff, b_off_ff;
  wire [3:0] nxt_a_off = i_bank_a_enable ? 4'h0 : a_off_ff + {3'h0, a_off_ff != 4'hF};
  wire [3:0] nxt_b_off = i_bank_b_enable ? 4'h0 : b_off_ff + {3'h0, b_off_ff != 4'hF};
  always_ff @(posedge i_clk_sys) begin
    a_off_ff <= i_reset_n ? nxt_a_off : 4'h0;
    b_off_ff <= i_reset_n ? nxt_b_off : 4'h0;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_bank_a_off: assert property (a_off_ff == 4'hF |-> o_bank_a_clock_outs == '0)
    else $error("bank a running while disabled");
  a_bank_b_off: assert property (b_off_ff == 4'hF |-> o_bank_b_clock_outs == '0)
    else $error("bank b running while disabled");
  a_lanes_equal: assert property ((&o_bank_a_clock_outs) == (|o_bank_a_clock_outs) && (&o_bank_b_clock_outs) == (|o_bank_b_clock_outs))
    else $error("bank lanes differ");
  a_bank_a_phase: assert property (o_bank_a_clock_outs[0] |-> o_loop_feedback_out)
    else $error("bank a high while feedback low");
  a_bank_b_phase: assert property (o_bank_b_clock_outs[0] |-> o_loop_feedback_out)
    else $error("bank b high while feedback low");
  a_fb_running: assert property (o_loop_locked |-> ##[1:16] $changed(o_loop_feedback_out))
    else $error("feedback output stalled");
  a_phase_aligned: assert property (o_loop_locked && i_analog_supply_bypass_strap && $rose(i_ref_clk) |-> (##[0:3] o_loop_feedback_out) or (##[1:6] !o_loop_locked))
    else $error("feedback not aligned to ref");
  a_bypass_mirror: assert property ((!i_analog_supply_bypass_strap)[*8] |-> o_loop_feedback_out == $past(i_ref_clk, 3))
    else $error("bypass output not ref delayed");
  a_lock_clear: assert property ($rose(i_reset_n) |-> !o_loop_locked)
    else $error("lock flag set out of reset");
endmodule
bind pll_clock_fanout_gating clk_fanout_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_clk_fanout_properties (
  .i_clk_sys, .i_reset_n, .i_ref_clk, .i_bank_a_enable, .i_bank_b_enable,
  .i_analog_supply_bypass_strap, .o_bank_a_clock_outs, .o_bank_b_clock_outs,
  .o_loop_feedback_out, .o_loop_locked);

/* File: clk_source_model.sv */
/* Reference source and board feedback wire.
   Assumes high and low times are given in 40 ns system cycles. */
`timescale 1ns/1ps
module clk_source_model (
  input wire logic [7:0] i_hi_cyc,
  input wire logic [7:0] i_lo_cyc,
  input wire logic i_loop_feedback_out,
  output logic o_ref_clk,
  output wire logic o_loop_feedback_in
);
  // Board trace closes the loop
  assign o_loop_feedback_in = i_loop_feedback_out;
  // Free-running ref; 7 ns skew keeps its edges off the system edge
  initial begin
    o_ref_clk = 1'b0;
    #7;
    forever begin
      o_ref_clk = 1'b1;
      #(i_hi_cyc * 40);
      o_ref_clk = 1'b0;
      #(i_lo_cyc * 40);
    end
  end
endmodule

/* File: pin_sync.sv */
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes each bit is a level; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Second stage is the only reader of the first
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

/* File: pll_clock_fanout_gating.sv */
/*
  Clock fan-out with a digital phase-tracking loop, two gated banks and an
  ungated feedback output, plus a test bypass.
  Assumes the reference, feedback return, bank enables and strap are pins that
  are asynchronous to i_clk_sys; all pass the two-stage synchroniser.
  The regenerated clocks are stepped on i_clk_sys, so their edges are quantised
  to 40 ns and their period must be at least four system cycles.
*/
`timescale 1ns/1ps
module pll_clock_fanout_gating #(
  parameter logic [clk_fanout_pkg::LOCK_W-1:0] LOCK_CYCLES = clk_fanout_pkg::LOCK_CYCLES_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ref_clk,
  input wire logic i_loop_feedback_in,
  input wire logic i_bank_a_enable,
  input wire logic i_bank_b_enable,
  input wire logic i_analog_supply_bypass_strap,
  output logic [clk_fanout_pkg::BANK_A_N-1:0] o_bank_a_clock_outs,
  output logic [clk_fanout_pkg::BANK_B_N-1:0] o_bank_b_clock_outs,
  output logic o_loop_feedback_out,
  output logic o_loop_locked
);

  localparam int PW = clk_fanout_pkg::PERIOD_W;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  clk_fanout_pkg::pin_in_t pin_raw;
  clk_fanout_pkg::pin_in_t pin_s;
  logic [clk_fanout_pkg::SYNC_W-1:0] pin_s_bits;

  assign pin_raw.ref_clk = i_ref_clk;
  assign pin_raw.loop_feedback_in = i_loop_feedback_in;
  assign pin_raw.bank_a_enable = i_bank_a_enable;
  assign pin_raw.bank_b_enable = i_bank_b_enable;
  assign pin_raw.analog_supply_bypass_strap = i_analog_supply_bypass_strap;

  pin_sync #(
    .W(clk_fanout_pkg::SYNC_W)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_async(pin_raw),
    .o_sync(pin_s_bits)
  );

  assign pin_s = clk_fanout_pkg::pin_in_t'(pin_s_bits);

  // ****************************************
  // Edge detection and decode
  // ****************************************
  logic ref_d_ff;
  logic fb_d_ff;
  logic ref_rise;
  logic fb_rise;
  logic bypass;

  assign ref_rise = pin_s.ref_clk & ~ref_d_ff;
  assign fb_rise = pin_s.loop_feedback_in & ~fb_d_ff;
  assign bypass = ~pin_s.analog_supply_bypass_strap;

  // ****************************************
  // Reference period measurement
  // ****************************************
  logic [PW-1:0] phase_cnt_ff;
  logic [PW-1:0] period_ff;
  logic period_valid_ff;
  logic seen_edge_ff;
  logic [PW-1:0] meas_period;
  logic [PW-1:0] period_diff;
  logic freq_changed;
  logic [PW-1:0] half_period;

  // Saturating count avoids a false short period when the reference stops
  assign meas_period = (phase_cnt_ff == clk_fanout_pkg::PERIOD_MAX) ?
                       phase_cnt_ff : phase_cnt_ff + 16'h0001;
  assign period_diff = (meas_period > period_ff) ? meas_period - period_ff :
                       period_ff - meas_period;
  assign freq_changed = ref_rise & seen_edge_ff &
                        (period_diff > clk_fanout_pkg::PERIOD_TOL);
  assign half_period = period_ff >> 1;

  // Phase counter restarts on each reference edge, period latched there
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ref_d_ff <= 1'b0;
      fb_d_ff <= 1'b0;
      phase_cnt_ff <= clk_fanout_pkg::PERIOD_RST;
      period_ff <= clk_fanout_pkg::PERIOD_RST;
      seen_edge_ff <= 1'b0;
      period_valid_ff <= 1'b0;
    end else begin
      ref_d_ff <= pin_s.ref_clk;
      fb_d_ff <= pin_s.loop_feedback_in;
      if (ref_rise) begin
        phase_cnt_ff <= clk_fanout_pkg::PERIOD_RST;
        seen_edge_ff <= 1'b1;
        if (seen_edge_ff) begin
          period_ff <= meas_period;
          period_valid_ff <= 1'b1;
        end
      end else if (phase_cnt_ff != clk_fanout_pkg::PERIOD_MAX) begin
        phase_cnt_ff <= phase_cnt_ff + 16'h0001;
      end
    end
  end

  // ****************************************
  // Lock interval
  // ****************************************
  logic [clk_fanout_pkg::LOCK_W-1:0] lock_cnt_ff;
  logic locked;

  assign locked = (lock_cnt_ff == LOCK_CYCLES);

  // Restart on a frequency step; outside bypass, bank outputs wait for it so loads see clean clocks
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || bypass || freq_changed || !period_valid_ff) begin
      lock_cnt_ff <= '0;
    end else if (!locked) begin
      lock_cnt_ff <= lock_cnt_ff + 24'h000001;
    end
  end

  // ****************************************
  // Phase tracking of the feedback return
  // ****************************************
  logic [PW-1:0] lead_ff;
  logic fb_lags;
  logic [PW-1:0] rise_pt;
  logic gen_rise;

  // Feedback edge early in the period means it lags the reference edge
  assign fb_lags = (phase_cnt_ff != clk_fanout_pkg::PERIOD_RST) &&
                   (phase_cnt_ff < half_period);
  // Phase P-1 is the ref_rise cycle itself, so a lead of L fires at P-1-L
  assign rise_pt = period_ff - lead_ff - 16'h0001;
  assign gen_rise = period_valid_ff &&
                    ((lead_ff == clk_fanout_pkg::PERIOD_RST) ? ref_rise :
                     (!ref_rise && phase_cnt_ff == rise_pt));

  // Bang-bang step of one cycle per feedback edge; settling takes one edge per cycle of phase error
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || bypass || freq_changed) begin
      lead_ff <= clk_fanout_pkg::PERIOD_RST;
    end else if (fb_rise && period_valid_ff && !ref_rise) begin
      if (fb_lags && lead_ff < half_period) begin
        lead_ff <= lead_ff + 16'h0001;
      end else if (!fb_lags && phase_cnt_ff != clk_fanout_pkg::PERIOD_RST &&
                   lead_ff != clk_fanout_pkg::PERIOD_RST) begin
        lead_ff <= lead_ff - 16'h0001;
      end
    end
  end

  // ****************************************
  // Regenerated clock
  // ****************************************
  logic gen_ff;
  logic [PW-1:0] high_cnt_ff;

  // High for half the measured period whatever the reference duty
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      gen_ff <= 1'b0;
      high_cnt_ff <= clk_fanout_pkg::PERIOD_RST;
    end else if (gen_rise) begin
      gen_ff <= 1'b1;
      high_cnt_ff <= half_period - 16'h0001;
    end else if (gen_ff) begin
      if (high_cnt_ff == clk_fanout_pkg::PERIOD_RST) begin
        gen_ff <= 1'b0;
      end else begin
        high_cnt_ff <= high_cnt_ff - 16'h0001;
      end
    end
  end

  // ****************************************
  // Output selection and bank gating
  // ****************************************
  logic core_clk;
  logic en_a_ff;
  logic en_b_ff;
  logic bank_live;
  clk_fanout_pkg::clk_out_t out_ff;
  clk_fanout_pkg::clk_out_t nxt_out;

  assign core_clk = bypass ? pin_s.ref_clk : gen_ff;
  assign bank_live = bypass | locked;
  assign nxt_out.bank_a = {clk_fanout_pkg::BANK_A_N{core_clk & en_a_ff & bank_live}};
  assign nxt_out.bank_b = {clk_fanout_pkg::BANK_B_N{core_clk & en_b_ff & bank_live}};
  assign nxt_out.fb_out = core_clk;

  // Enables only change while the clock is low, so no runt pulse escapes
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      en_a_ff <= 1'b0;
      en_b_ff <= 1'b0;
      out_ff <= '0;
    end else begin
      if (!core_clk) begin
        en_a_ff <= pin_s.bank_a_enable;
        en_b_ff <= pin_s.bank_b_enable;
      end
      out_ff <= nxt_out;
    end
  end

  assign o_bank_a_clock_outs = out_ff.bank_a;
  assign o_bank_b_clock_outs = out_ff.bank_b;
  assign o_loop_feedback_out = out_ff.fb_out;
  assign o_loop_locked = locked;

endmodule

/* File: tb_top.sv */
/* Self-checking bench for the clock fan-out block.
   Assumes the bound checker and the reference source model. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, strap = 1'b1, en_a = 1'b0, en_b = 1'b0;
  logic [7:0] hi = 8'h04, lo = 8'h04, h;
  logic ref_clk, fb_in, fb_out, locked;
  logic [4:0] bank_a, a_s;
  logic [3:0] bank_b, b_s;
  logic [16:0] notes[$], exp_n;
  int n_errors = 0, comparisons = 0, run = 0, k;
  always #20 i_clk_sys = ~i_clk_sys;
  clk_source_model u_clk_source_model (.i_hi_cyc(hi), .i_lo_cyc(lo),
    .i_loop_feedback_out(fb_out), .o_ref_clk(ref_clk), .o_loop_feedback_in(fb_in));
  pll_clock_fanout_gating #(.LOCK_CYCLES(24'h000010)) u_pll_clock_fanout_gating (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ref_clk(ref_clk),
    .i_loop_feedback_in(fb_in), .i_bank_a_enable(en_a), .i_bank_b_enable(en_b),
    .i_analog_supply_bypass_strap(strap), .o_bank_a_clock_outs(bank_a),
    .o_bank_b_clock_outs(bank_b), .o_loop_feedback_out(fb_out), .o_loop_locked(locked));
  // ****************
  // Tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // Sampled mid-cycle so the registered flag has settled
  task automatic wait_lock(input logic v);
    for (k = 0; k < 800 && locked !== v; k++) @(negedge i_clk_sys);
    `CHK("locked", v, locked)
    cyc(1);
  endtask
  // Notes start after a low phase so no partial run is measured
  task automatic expect_runs(input logic [7:0] n_hi);
    cyc(24);
    while (fb_out !== 1'b0) @(negedge i_clk_sys);
    cyc(2);
    repeat (2) notes.push_back({n_hi, {5{en_a}}, {4{en_b}}});
    for (k = 0; k < 100 && notes.size() != 0; k++) cyc(1);
    `CHK("notes drained", 0, notes.size())
  endtask
  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Monitor: high-run length and bank levels at each feedback fall
  always @(negedge i_clk_sys) begin
    if (fb_out === 1'b1) begin
      run++;
      a_s = bank_a;
      b_s = bank_b;
    end else begin
      if (run != 0 && notes.size() != 0) begin
        exp_n = notes.pop_front();
        `CHK("run and banks", exp_n, {run[7:0], a_s, b_s})
      end
      run = 0;
    end
  end
  initial begin
    cyc(20000);
    n_errors++;
    finish_test();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(24));
    cyc(3);
    i_reset_n <= 1'b1;
    h = 8'(1 + $urandom % 7);
    hi <= h;
    lo <= 8'h08 - h;
    wait_lock(1'b1);
    for (int e = 0; e < 4; e++) begin
      {en_a, en_b} <= e[1:0];
      expect_runs(8'h04);
    end
    hi <= 8'h06;
    lo <= 8'h06;
    wait_lock(1'b0);
    wait_lock(1'b1);
    expect_runs(8'h06);
    // Bypass keeps the ref duty, no correction
    h = 8'(1 + $urandom % 7);
    strap <= 1'b0;
    hi <= h;
    lo <= 8'h08 - h;
    expect_runs(h);
    i_reset_n <= 1'b0;
    strap <= 1'b1;
    cyc(3);
    i_reset_n <= 1'b1;
    wait_lock(1'b1);
    `CHK("pending notes", 0, notes.size())
    finish_test();
  end
endmodule
